// File: bench/tb_top.sv
// tb_top: bit-banged two-wire host plus line, sample and bit stimulus for the slicer bank
// assumes: vst_regs and its checker compiled first; sda pulled up, device open drain
`timescale 1ns/1ps
module tb_top;
  import vst_pkg::*;
  localparam logic [6:0] DEV = 7'h2a; // arbitrary, the design default
  logic core_clk_in, rst_n_in, scl_m, sda_m, line_start_in, sample_valid_in, bit_valid_in;
  logic bit_in, runin_byte_seen_in, sda_out, sda_oe_out, sample_keep_out, bit_valid_out;
  logic bit_out, slicer_start_out;
  logic [2:0] coeff_select_in;
  vst_cap_cfg_s cap_cfg_out;
  vst_eq_cfg_s eq_cfg_out;
  logic [9:0] teletext_hysteresis_out;
  logic [15:0] eq_coeff_word_out, c;
  logic [15:0] exp_q[$], obs_q[$];
  logic [7:0] v4b, v4c, v4f, v50, v52;
  logic [7:0] bank[16] = '{8'h0d, 8'h08, 8'h63, 8'h1c, 8'h46, 8'h00, 8'h00, 8'h00, 8'hb3,
    8'h08, 8'h71, 8'h0c, 8'h00, 8'h00, 8'h15, 8'ha0};
  logic [19:0] pat = 20'h0_8c70;
  int n_fail = 0, num_checks = 0, seed = 4, keeps = 0, rises = 0;
  wire sda_line = sda_m & ~(sda_oe_out & ~sda_out);

  vst_regs vst_regs_i (.core_clk_in, .rst_n_in, .scl_in(scl_m), .sda_in(sda_line), .sda_out,
    .sda_oe_out, .line_start_in, .coeff_select_in, .sample_valid_in, .sample_keep_out,
    .bit_valid_in, .bit_in, .bit_valid_out, .bit_out, .runin_byte_seen_in, .slicer_start_out,
    .cap_cfg_out, .teletext_hysteresis_out, .eq_cfg_out, .eq_coeff_word_out);

  initial begin
    core_clk_in = 0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in) begin
    if (sample_keep_out === 1'b1) keeps++;
    if ($rose(bit_out)) rises++;
  end

  always @(negedge core_clk_in) begin
    while (obs_q.size() > 0) cmp_val(exp_q.pop_front(), obs_q.pop_front());
  end

  task automatic cmp_val(input logic [15:0] e, input logic [15:0] o);
    num_checks++;
    if (o !== e) begin
      n_fail++;
      $display("mismatch at %0t: expected %h got %h", $time, e, o);
    end
  endtask : cmp_val

  task automatic note(input logic [15:0] e, input logic [15:0] o);
    exp_q.push_back(e);
    obs_q.push_back(o);
  endtask : note

  task automatic wrap_up;
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : cyc

  // start is cond(1,0), stop is cond(0,1); scl phases kept well above four cycles
  task automatic cond(input logic a, input logic b);
    cyc(2);
    sda_m = a;
    cyc(6);
    scl_m = 1;
    cyc(6);
    sda_m = b;
    cyc(6);
    scl_m = b;
  endtask : cond

  task automatic xbit(input logic b, output logic r);
    cyc(2);
    sda_m = b;
    cyc(6);
    scl_m = 1;
    cyc(4);
    r = sda_line;
    cyc(4);
    scl_m = 0;
  endtask : xbit

  task automatic xbyte(input logic [7:0] dt, input logic wr, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) xbit(dt[i], r[i]);
    xbit(1'b1, a);
    if (wr) note(16'h0000, {15'h0, a});
  endtask : xbyte

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] dt);
    logic [7:0] r;
    cond(1, 0);
    xbyte({DEV, 1'b0}, 1, r);
    xbyte(a, 1, r);
    xbyte(dt, 1, r);
    cond(0, 1);
    if (a >= 8'h43 && a <= 8'h52) bank[a - 8'h43] = dt;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    cond(1, 0);
    xbyte({DEV, 1'b0}, 1, r);
    xbyte(a, 1, r);
    cond(1, 0);
    xbyte({DEV, 1'b1}, 1, r);
    xbyte(8'hff, 0, r);
    cond(0, 1);
    note({8'h00, e}, {8'h00, r});
  endtask : rd_chk

  task automatic rd_all;
    for (int i = 0; i < 16; i++) rd_chk(8'h43 + 8'(i), bank[i]);
  endtask : rd_all

  task automatic line;
    line_start_in = 1;
    cyc(1);
    line_start_in = 0;
    cyc(2);
  endtask : line

  initial begin
    rst_n_in = 0;
    scl_m = 1;
    sda_m = 1;
    line_start_in = 0;
    coeff_select_in = 3'h0;
    sample_valid_in = 0;
    bit_valid_in = 0;
    bit_in = 0;
    runin_byte_seen_in = 0;
    cyc(16);
    rst_n_in = 1;
    cyc(4);
    note(16'hb308, cap_cfg_out);
    rd_all;
    wr_reg(8'h43, 8'h0d);
    for (int i = 8'h48; i < 8'h4b; i++) wr_reg(8'(i), 8'h1b);
    v4b = $random(seed);
    v4c = $random(seed);
    v4f = $random(seed);
    v50 = {6'h03, 2'($random(seed))};
    v52 = {2'h0, 1'($random(seed)), 5'h00};
    wr_reg(8'h4b, v4b);
    wr_reg(8'h4c, v4c);
    wr_reg(8'h4f, v4f);
    wr_reg(8'h50, v50);
    wr_reg(8'h52, v52);
    wr_reg(8'h60, 8'h5a);
    rd_chk(8'h60, 8'h00);
    note(16'hb308, cap_cfg_out);
    line;
    note({v4b, v4c}, cap_cfg_out);
    note({6'h00, v50[1:0], v4f}, {6'h00, teletext_hysteresis_out});
    note({14'h0, v52[6:5]}, {14'h0, eq_cfg_out[6:5]});
    rd_all;
    // table commit: live mode bit set, entry chosen by the selection code
    coeff_select_in = 3'h6;
    c = $random(seed);
    wr_reg(8'h52, 8'h40);
    wr_reg(8'h49, c[7:0]);
    wr_reg(8'h4a, c[15:8]);
    line;
    cyc(3);
    note(c, eq_coeff_word_out);
    wr_reg(8'h52, 8'h00);
    wr_reg(8'h49, ~c[7:0]);
    wr_reg(8'h4a, ~c[15:8]);
    line;
    cyc(3);
    note(~c, eq_coeff_word_out);
    wr_reg(8'h52, 8'h40);
    line;
    cyc(3);
    note(c, eq_coeff_word_out);
    for (int k = 0; k < 8; k++) begin
      coeff_select_in = k[2:0];
      cyc(3);
      note({13'h0, k[2:0]}, {13'h0, eq_cfg_out.preset_code});
      note({14'h0, k == 4 ? VST_EQ_SRC_AUTO : k == 6 ? VST_EQ_SRC_PROG : VST_EQ_SRC_PRESET},
        {14'h0, eq_cfg_out.source});
      if (k != 6) note(16'h0000, eq_coeff_word_out);
    end
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'h4b, {3'h5, k[1:0], 3'h3});
      line;
      keeps = 0;
      sample_valid_in = 1;
      cyc(12);
      sample_valid_in = 0;
      cyc(3);
      note(16'(12 / (k + 1)), 16'(keeps));
    end
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h4c, {m[1:0], 6'h08});
      line;
      rises = 0;
      for (int i = 19; i >= 0; i--) begin
        bit_valid_in = 1;
        bit_in = pat[i];
        cyc(1);
      end
      bit_valid_in = 0;
      cyc(4);
      note(m == 0 ? 16'h3 : m == 1 ? 16'h2 : 16'h1, 16'(rises));
    end
    line;
    for (int i = 0; i < 3; i++) begin
      note(16'h0000, {15'h0, slicer_start_out});
      runin_byte_seen_in = 1;
      cyc(1);
      runin_byte_seen_in = 0;
      cyc(3);
    end
    note(16'h0001, {15'h0, slicer_start_out});
    line;
    note(16'h0000, {15'h0, slicer_start_out});
    cyc(4);
    wrap_up;
  end

  initial begin
    #300000;
    n_fail++;
    wrap_up;
  end
endmodule : tb_top

// File: bench/vst_regs_sva.sv
// vst_regs_sva: port-level checks of the slicer tuning bank
// assumes: bound to vst_regs, one clock, asynchronous active-low reset
`timescale 1ns/1ps
`include "vst_cfg.svh"
module vst_regs_sva (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic line_start_in,
  input wire logic [2:0] coeff_select_in,
  input wire logic sample_valid_in,
  input wire logic sample_keep_out,
  input wire logic bit_valid_in,
  input wire logic bit_in,
  input wire logic bit_valid_out,
  input wire logic bit_out,
  input wire logic runin_byte_seen_in,
  input wire logic slicer_start_out,
  input wire vst_pkg::vst_cap_cfg_s cap_cfg_out,
  input wire logic [9:0] teletext_hysteresis_out,
  input wire vst_pkg::vst_eq_cfg_s eq_cfg_out,
  input wire logic [15:0] eq_coeff_word_out
);
  import vst_pkg::*;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence code_s(logic [2:0] c);
    coeff_select_in == c;
  endsequence
  // word output lags the source by a cycle, so two quiet cycles suffice; three are checked
  sequence not_prog_s;
    (eq_cfg_out.source != VST_EQ_SRC_PROG) [*3];
  endsequence
  cfg_hold_a: assert property (!line_start_in |=> $stable(cap_cfg_out))
    else $error("caption settings moved between line starts");
  hyst_hold_a: assert property (!line_start_in |=> $stable(teletext_hysteresis_out))
    else $error("hysteresis moved between line starts");
  eq_hold_a: assert property (!line_start_in |=> $stable(eq_cfg_out[6:5]))
    else $error("equaliser mode moved between line starts");
  auto_src_a: assert property (code_s(`VST_EQ_CODE_AUTO)
    |=> eq_cfg_out.source == VST_EQ_SRC_AUTO)
    else $error("automatic code did not select automatic source");
  prog_src_a: assert property (code_s(`VST_EQ_CODE_PROG)
    |=> eq_cfg_out.source == VST_EQ_SRC_PROG)
    else $error("programmed code did not select programmed source");
  word_idle_a: assert property (not_prog_s |-> eq_coeff_word_out == 16'h0000)
    else $error("coefficient word driven outside programmed source");
  keep_cause_a: assert property (sample_keep_out |-> $past(sample_valid_in))
    else $error("kept sample without an input sample");
  keep_all_a: assert property (sample_valid_in && !line_start_in
    && cap_cfg_out.sample_decimation == 2'h0 |=> sample_keep_out)
    else $error("decimation code zero dropped a sample");
  bit_pass_a: assert property (bit_valid_in && !line_start_in && cap_cfg_out[7:6] == 2'h0
    |=> bit_valid_out && bit_out == $past(bit_in))
    else $error("unfiltered bit not passed through");
  start_clear_a: assert property (line_start_in
    |=> !slicer_start_out || cap_cfg_out.runin_byte_count == 3'h0)
    else $error("slicer start not cleared by line start");
endmodule : vst_regs_sva

bind vst_regs vst_regs_sva vst_regs_sva_i (.core_clk_in, .rst_n_in, .scl_in, .sda_in, .sda_out,
  .sda_oe_out, .line_start_in, .coeff_select_in, .sample_valid_in, .sample_keep_out,
  .bit_valid_in, .bit_in, .bit_valid_out, .bit_out, .runin_byte_seen_in, .slicer_start_out,
  .cap_cfg_out, .teletext_hysteresis_out, .eq_cfg_out, .eq_coeff_word_out);

// File: src/vst_cfg.svh
// vst_cfg.svh: register offsets, field positions, reset values and codes of the slicer bank
// assumes: included by name from vst_regs and from its checker
`ifndef VST_CFG_SVH
`define VST_CFG_SVH

`define VST_OFS_FIRST 8'h43
`define VST_OFS_RSV_A 8'h43
`define VST_OFS_RSV_B 8'h44
`define VST_OFS_RSV_C 8'h45
`define VST_OFS_RSV_D 8'h46
`define VST_OFS_RSV_E 8'h47
`define VST_OFS_RSV_F 8'h48
`define VST_OFS_COEF_A 8'h49
`define VST_OFS_COEF_B 8'h4a
`define VST_OFS_CAP_TIMING 8'h4b
`define VST_OFS_SPIKE_SPB 8'h4c
`define VST_OFS_RSV_G 8'h4d
`define VST_OFS_RSV_H 8'h4e
`define VST_OFS_HYST_LO 8'h4f
`define VST_OFS_HYST_HI 8'h50
`define VST_OFS_RSV_I 8'h51
`define VST_OFS_EQ_MODE 8'h52
`define VST_REG_COUNT 16

`define VST_RST_RSV_A 8'h0d
`define VST_RST_RSV_B 8'h08
`define VST_RST_RSV_C 8'h63
`define VST_RST_RSV_D 8'h1c
`define VST_RST_RSV_E 8'h46
`define VST_RST_RSV_F 8'h00
`define VST_RST_COEF_A 8'h00
`define VST_RST_COEF_B 8'h00
`define VST_RST_CAP_TIMING 8'hb3
`define VST_RST_SPIKE_SPB 8'h08
`define VST_RST_RSV_G 8'h71
`define VST_RST_RSV_H 8'h0c
`define VST_RST_HYST_LO 8'h00
`define VST_RST_HYST_HI 8'h00
`define VST_RST_RSV_I 8'h15
`define VST_RST_EQ_MODE 8'ha0

`define VST_SCW_MSB 7
`define VST_SCW_LSB 5
`define VST_DEC_MSB 4
`define VST_DEC_LSB 3
`define VST_RUNIN_MSB 2
`define VST_RUNIN_LSB 0
`define VST_SPF2_BIT 7
`define VST_SPF1_BIT 6
`define VST_SPB_MSB 5
`define VST_SPB_LSB 0
`define VST_HYH_MSB 1
`define VST_HYH_LSB 0
`define VST_EQW_BIT 6
`define VST_EQO_BIT 5

`define VST_EQ_CODE_AUTO 3'h4
`define VST_EQ_CODE_PROG 3'h6

`endif

// File: src/vst_coef_mem.sv
// vst_coef_mem: equaliser coefficient table, one write port, registered read
// assumes: single clock, read address from logic on the same clock
`timescale 1ns/1ps
module vst_coef_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  // storage holds no reset; only the read register does
  always_ff @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_reg[rd_addr_in];
    end
  end
endmodule : vst_coef_mem

// File: src/vst_pkg.sv
// vst_pkg: types shared by the slicer tuning bank
// assumes: no include; uses no vst_cfg.svh macros
package vst_pkg;
  typedef enum logic [2:0] {
    VST_ST_IDLE = 3'h0,
    VST_ST_RX = 3'h1,
    VST_ST_ACK = 3'h3,
    VST_ST_TX = 3'h2,
    VST_ST_RACK = 3'h6
  } vst_i2c_state_e;

  typedef enum logic [1:0] {
    VST_EQ_SRC_PRESET = 2'h0,
    VST_EQ_SRC_AUTO = 2'h1,
    VST_EQ_SRC_PROG = 2'h2
  } vst_eq_src_e;

  typedef struct packed {
    logic [2:0] shift_comp_window;
    logic [1:0] sample_decimation;
    logic [2:0] runin_byte_count;
    logic two_sample_spike_filter_en;
    logic one_sample_spike_filter_en;
    logic [5:0] samples_per_bit;
  } vst_cap_cfg_s;

  typedef struct packed {
    logic equaliser_table_writable;
    logic equaliser_order_select;
    vst_eq_src_e source;
    logic [2:0] preset_code;
  } vst_eq_cfg_s;
endpackage : vst_pkg

// File: src/vst_regs.sv
// vst_regs: slicer tuning bank behind the two-wire serial port, with line-aligned apply
// assumes: scl/sda from pins, all other inputs from logic on core_clk_in
//
// Contract
// - 4Bh top three bits: shift compensation window
// - decimation code; code 10 keeps one of three
// - 4Bh low bits: run-in bytes before slicing
// - 4Ch bit7 enables two-sample spike filter
// - 4Ch bit6 enables one-sample spike filter
// - 4Ch low six bits: samples per bit
// - hysteresis ten bits: 4Fh low, 50h[1:0]
// - 52h bit6 set makes coefficient table writable
// - written coefficient goes to selected table entry
// - 52h bit5: 0 second order, 1 first
// - code 100 automatic, 110 programmed coefficients
`timescale 1ns/1ps
`include "vst_cfg.svh"
module vst_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a, // arbitrary default
  parameter int TABLE_DEPTH = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic line_start_in,
  input wire logic [2:0] coeff_select_in,
  input wire logic sample_valid_in,
  output logic sample_keep_out,
  input wire logic bit_valid_in,
  input wire logic bit_in,
  output logic bit_valid_out,
  output logic bit_out,
  input wire logic runin_byte_seen_in,
  output logic slicer_start_out,
  output vst_pkg::vst_cap_cfg_s cap_cfg_out,
  output logic [9:0] teletext_hysteresis_out,
  output vst_pkg::vst_eq_cfg_s eq_cfg_out,
  output logic [15:0] eq_coeff_word_out
);
  import vst_pkg::*;

  function automatic logic [8:0] reg_index(input logic [7:0] ofs);
    logic [7:0] idx;
    idx = ofs - `VST_OFS_FIRST;
    reg_index = {(ofs >= `VST_OFS_FIRST) && (idx < 8'(`VST_REG_COUNT)), idx};
  endfunction : reg_index

  function automatic vst_cap_cfg_s cap_fields(input logic [7:0] timing, input logic [7:0] spb);
    vst_cap_cfg_s c;
    c.shift_comp_window = timing[`VST_SCW_MSB:`VST_SCW_LSB];
    c.sample_decimation = timing[`VST_DEC_MSB:`VST_DEC_LSB];
    c.runin_byte_count = timing[`VST_RUNIN_MSB:`VST_RUNIN_LSB];
    c.two_sample_spike_filter_en = spb[`VST_SPF2_BIT];
    c.one_sample_spike_filter_en = spb[`VST_SPF1_BIT];
    c.samples_per_bit = spb[`VST_SPB_MSB:`VST_SPB_LSB];
    cap_fields = c;
  endfunction : cap_fields

  localparam logic [3:0] IDX_COEF_A = 4'(`VST_OFS_COEF_A - `VST_OFS_FIRST);
  localparam logic [3:0] IDX_COEF_B = 4'(`VST_OFS_COEF_B - `VST_OFS_FIRST);
  localparam logic [3:0] IDX_TIMING = 4'(`VST_OFS_CAP_TIMING - `VST_OFS_FIRST);
  localparam logic [3:0] IDX_SPB = 4'(`VST_OFS_SPIKE_SPB - `VST_OFS_FIRST);
  localparam logic [3:0] IDX_HLO = 4'(`VST_OFS_HYST_LO - `VST_OFS_FIRST);
  localparam logic [3:0] IDX_HHI = 4'(`VST_OFS_HYST_HI - `VST_OFS_FIRST);
  localparam logic [3:0] IDX_EQ = 4'(`VST_OFS_EQ_MODE - `VST_OFS_FIRST);
  // reset image of the bank, lowest offset in the lowest byte
  localparam logic [`VST_REG_COUNT-1:0][7:0] RST_IMAGE = {`VST_RST_EQ_MODE, `VST_RST_RSV_I,
    `VST_RST_HYST_HI, `VST_RST_HYST_LO, `VST_RST_RSV_H, `VST_RST_RSV_G, `VST_RST_SPIKE_SPB,
    `VST_RST_CAP_TIMING, `VST_RST_COEF_B, `VST_RST_COEF_A, `VST_RST_RSV_F, `VST_RST_RSV_E,
    `VST_RST_RSV_D, `VST_RST_RSV_C, `VST_RST_RSV_B, `VST_RST_RSV_A};
  // pin synchronisers: [0] first flop, [1] second, [2] edge history of [1]
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_now;
  assign sda_now = sda_sync_reg[1];
  assign scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
  assign scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
  assign start_det = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[2] & ~sda_now;
  assign stop_det = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[2] & sda_now;

  vst_i2c_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [1:0] phase_reg;
  logic read_reg;
  logic [7:0] ptr_reg;
  logic wr_stb_reg;
  logic [7:0] wr_ofs_reg;
  logic [7:0] wr_data_reg;
  logic [7:0] bank_reg [`VST_REG_COUNT];
  logic [7:0] rd_byte;
  logic [8:0] rd_hit;
  logic [8:0] wr_hit;

  // unmapped offsets read as zero and swallow writes, but still acknowledge
  assign rd_hit = reg_index(ptr_reg);
  assign rd_byte = rd_hit[8] ? bank_reg[rd_hit[3:0]] : 8'h00;
  assign wr_hit = reg_index(wr_ofs_reg);

  // serial protocol: slave address, sub-address, then auto-incremented data
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= VST_ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      phase_reg <= 2'h0;
      read_reg <= 1'b0;
      ptr_reg <= 8'h00;
      wr_stb_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      sda_oe_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      wr_stb_reg <= 1'b0;
      sda_out <= 1'b0; // open drain: only the enable moves
      if (start_det) begin
        state_reg <= VST_ST_RX;
        bit_cnt_reg <= 4'h0;
        phase_reg <= 2'h0;
        sda_oe_out <= 1'b0;
      end else if (stop_det) begin
        state_reg <= VST_ST_IDLE;
        sda_oe_out <= 1'b0;
      end else begin
        case (state_reg)
          VST_ST_IDLE: begin
            sda_oe_out <= 1'b0;
          end
          VST_ST_RX: begin
            if (scl_rise && bit_cnt_reg != 4'h8) begin
              shift_reg <= {shift_reg[6:0], sda_now};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              case (phase_reg)
                2'h0: begin
                  if (shift_reg[7:1] == SLAVE_ADDR) begin
                    read_reg <= shift_reg[0];
                    phase_reg <= shift_reg[0] ? 2'h2 : 2'h1;
                    sda_oe_out <= 1'b1;
                    state_reg <= VST_ST_ACK;
                  end else begin
                    state_reg <= VST_ST_IDLE;
                  end
                end
                2'h1: begin
                  ptr_reg <= shift_reg;
                  phase_reg <= 2'h2;
                  sda_oe_out <= 1'b1;
                  state_reg <= VST_ST_ACK;
                end
                default: begin
                  wr_stb_reg <= 1'b1;
                  wr_ofs_reg <= ptr_reg;
                  wr_data_reg <= shift_reg;
                  ptr_reg <= ptr_reg + 8'h01;
                  sda_oe_out <= 1'b1;
                  state_reg <= VST_ST_ACK;
                end
              endcase
            end
          end
          VST_ST_ACK: begin
            if (scl_fall) begin
              if (read_reg) begin
                shift_reg <= rd_byte;
                sda_oe_out <= ~rd_byte[7];
                bit_cnt_reg <= 4'h1;
                ptr_reg <= ptr_reg + 8'h01;
                state_reg <= VST_ST_TX;
              end else begin
                sda_oe_out <= 1'b0;
                state_reg <= VST_ST_RX;
              end
            end
          end
          VST_ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                sda_oe_out <= 1'b0;
                state_reg <= VST_ST_RACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_oe_out <= ~shift_reg[6];
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          VST_ST_RACK: begin
            if (scl_rise && sda_now) begin
              state_reg <= VST_ST_IDLE;
            end else if (scl_fall) begin
              shift_reg <= rd_byte;
              sda_oe_out <= ~rd_byte[7];
              bit_cnt_reg <= 4'h1;
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= VST_ST_TX;
            end
          end
          default: begin
            state_reg <= VST_ST_IDLE;
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // reserved bytes are plain storage; the host owns their mandatory values
  genvar gi;
  generate
    for (gi = 0; gi < `VST_REG_COUNT; gi++) begin : g_bank
      always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          bank_reg[gi] <= RST_IMAGE[gi];
        end else if (wr_stb_reg && wr_hit[8] && wr_hit[3:0] == 4'(gi)) begin
          bank_reg[gi] <= wr_data_reg;
        end
      end
    end
  endgenerate

  // live timing, hysteresis and mode bytes are copied to the slicer only at a line boundary
  vst_cap_cfg_s cap_live;
  assign cap_live = cap_fields(bank_reg[IDX_TIMING], bank_reg[IDX_SPB]);
  // the coefficient source follows the selector every cycle, not the line
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap_cfg_out <= cap_fields(RST_IMAGE[IDX_TIMING], RST_IMAGE[IDX_SPB]);
      teletext_hysteresis_out <= {RST_IMAGE[IDX_HHI][`VST_HYH_MSB:`VST_HYH_LSB],
                                  RST_IMAGE[IDX_HLO]};
      eq_cfg_out <= {RST_IMAGE[IDX_EQ][`VST_EQW_BIT], RST_IMAGE[IDX_EQ][`VST_EQO_BIT],
                     VST_EQ_SRC_PRESET, 3'h0};
    end else begin
      eq_cfg_out.preset_code <= coeff_select_in;
      case (coeff_select_in)
        `VST_EQ_CODE_AUTO: eq_cfg_out.source <= VST_EQ_SRC_AUTO;
        `VST_EQ_CODE_PROG: eq_cfg_out.source <= VST_EQ_SRC_PROG;
        default: eq_cfg_out.source <= VST_EQ_SRC_PRESET;
      endcase
      if (line_start_in) begin
        cap_cfg_out <= cap_live;
        teletext_hysteresis_out <= {bank_reg[IDX_HHI][`VST_HYH_MSB:`VST_HYH_LSB],
                                    bank_reg[IDX_HLO]};
        eq_cfg_out.equaliser_table_writable <= bank_reg[IDX_EQ][`VST_EQW_BIT];
        eq_cfg_out.equaliser_order_select <= bank_reg[IDX_EQ][`VST_EQO_BIT];
      end
    end
  end

  // a table entry is committed when the high coefficient byte lands
  logic tbl_we;
  logic [15:0] tbl_rdata;
  assign tbl_we = wr_stb_reg && wr_hit[8] && wr_hit[3:0] == IDX_COEF_B
                  && bank_reg[IDX_EQ][`VST_EQW_BIT];

  vst_coef_mem #(
    .WIDTH(16),
    .DEPTH(TABLE_DEPTH),
    .AW(3)
  ) u_coef_mem (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(tbl_we),
    .wr_addr_in(coeff_select_in),
    .wr_data_in({wr_data_reg, bank_reg[IDX_COEF_A]}),
    .rd_addr_in(coeff_select_in),
    .rd_data_out(tbl_rdata)
  );

  // programmed word: the table when writable, else the two raw coefficient bytes
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eq_coeff_word_out <= 16'h0000;
    end else if (eq_cfg_out.source == VST_EQ_SRC_PROG) begin
      eq_coeff_word_out <= eq_cfg_out.equaliser_table_writable ? tbl_rdata
                           : {bank_reg[IDX_COEF_B], bank_reg[IDX_COEF_A]};
    end else begin
      eq_coeff_word_out <= 16'h0000;
    end
  end

  // sample decimation: keep one sample in (code + 1)
  logic [1:0] dec_cnt_reg;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dec_cnt_reg <= 2'h0;
      sample_keep_out <= 1'b0;
    end else if (line_start_in) begin
      dec_cnt_reg <= 2'h0;
      sample_keep_out <= 1'b0;
    end else begin
      sample_keep_out <= sample_valid_in && dec_cnt_reg == 2'h0;
      if (sample_valid_in) begin
        dec_cnt_reg <= (dec_cnt_reg == cap_cfg_out.sample_decimation) ? 2'h0
                       : dec_cnt_reg + 2'h1;
      end
    end
  end

  // spike filter: a change must persist one sample longer than the glitch it rejects
  logic [1:0] run_reg;
  logic [1:0] run_need;
  assign run_need = cap_cfg_out.two_sample_spike_filter_en ? 2'h2
                    : {1'b0, cap_cfg_out.one_sample_spike_filter_en};
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_reg <= 2'h0;
      bit_out <= 1'b0;
      bit_valid_out <= 1'b0;
    end else begin
      bit_valid_out <= bit_valid_in;
      if (bit_valid_in) begin
        if (bit_in == bit_out) begin
          run_reg <= 2'h0;
        end else if (run_reg >= run_need) begin
          bit_out <= bit_in;
          run_reg <= 2'h0;
        end else begin
          run_reg <= run_reg + 2'h1;
        end
      end
    end
  end

  // run-in gate: slicing starts once the programmed count of bytes is seen
  logic [2:0] runin_cnt_reg;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      runin_cnt_reg <= 3'h0;
      slicer_start_out <= 1'b0;
    end else if (line_start_in) begin
      runin_cnt_reg <= 3'h0;
      slicer_start_out <= 1'b0;
    end else begin
      if (runin_byte_seen_in && runin_cnt_reg != 3'h7) begin
        runin_cnt_reg <= runin_cnt_reg + 3'h1;
      end
      if (runin_cnt_reg >= cap_cfg_out.runin_byte_count) begin
        slicer_start_out <= 1'b1;
      end
    end
  end
endmodule : vst_regs
